//--- shared/mcalu_pkg.sv
// Constants, types and register map of the microcore ALU datapath
package mcalu_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_GPR0 = 8'h00;
  localparam logic [7:0] ADDR_GPR_LAST = 8'h1c;
  localparam logic [7:0] ADDR_COND = 8'h20;
  localparam logic [7:0] ADDR_IMM_LO = 8'h24;
  localparam logic [7:0] ADDR_IMM_HI = 8'h28;
  localparam logic [7:0] ADDR_IMM = 8'h2c;
  localparam logic [7:0] ADDR_CMD = 8'h30;
  localparam logic [7:0] ADDR_JT_ONE = 8'h34;
  localparam logic [7:0] ADDR_JT_TWO = 8'h38;
  localparam logic [7:0] ADDR_BR_CTL = 8'h3c;
  localparam logic [7:0] ADDR_BR_DEST = 8'h40;
  // Condition register bit positions
  localparam int FLG_SHIFT_OUT = 15;
  localparam int FLG_SIGN_PROD = 14;
  localparam int FLG_CARRY = 13;
  localparam int FLG_LIM_HI = 12;
  localparam int FLG_LIM_LO = 11;
  localparam int FLG_MASK_ZERO = 10;
  localparam int FLG_MASK_ONE = 9;
  localparam int FLG_PROD_HI = 8;
  localparam int FLG_PROD_LO = 7;
  localparam int FLG_ZERO = 6;
  localparam int FLG_NEG = 5;
  localparam int FLG_U_UND = 4;
  localparam int FLG_U_OVR = 3;
  localparam int FLG_S_UND = 2;
  localparam int FLG_S_OVR = 1;
  localparam int FLG_DONE = 0;
  // Limiting modes
  localparam logic [1:0] LIM_SIGNED = 2'h1;
  localparam logic [1:0] LIM_UNSIGNED = 2'h3;
  localparam logic [15:0] SAT_S_MAX = 16'h7fff;
  localparam logic [15:0] SAT_S_MIN = 16'h8000;
  localparam logic [15:0] SAT_U_MAX = 16'hffff;
  localparam logic [15:0] SAT_U_MIN = 16'h0000;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DST_LSB = 5;
  localparam int CMD_SRC_LSB = 8;
  localparam int CMD_IMM_BIT = 11;
  localparam int CMD_CNT_LSB = 12;
  localparam int CMD_RST_BIT = 16;
  localparam int CMD_MODE_LSB = 17;
  // Branch control fields
  localparam int BR_PC_LSB = 0;
  localparam int BR_OFF_LSB = 10;
  localparam int BR_SEL_LSB = 15;
  localparam logic [1:0] BR_SEL_ONE = 2'h1;
  localparam logic [1:0] BR_SEL_TWO = 2'h2;
  // Fixed register indices and counts
  localparam logic [2:0] GPR_PROD_HI = 3'h6;
  localparam logic [2:0] GPR_PROD_LO = 3'h7;
  localparam logic [4:0] MUL_STEPS = 5'h10;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_AND, OP_NOT, OP_OR, OP_XOR, OP_INV, OP_TO_SIGNED, OP_TOINT,
    OP_SHL, OP_SHR, OP_SHLS, OP_SHRS, OP_WIDE_LEFT, OP_WIDE_RIGHT, OP_BYTE_LEFT, OP_BYTE_RIGHT, OP_SWAP, OP_STAL
  } mcalu_op_t;

  typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_SHIFT, ST_SHIFT32} mcalu_state_t;
endpackage

//--- src/mcalu_top.sv
// Microcore ALU datapath with AXI4-Lite register access
`timescale 1ns/1ps
module mcalu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status
  output logic operation_done_flag
);

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Nonzero test shared by flags
  function automatic logic nz16(input logic [15:0] v);
    nz16 = |v;
  endfunction

  logic [15:0] general_regs [8];
  logic [15:0] cond_ff;
  logic [15:0] imm_ff;
  logic [9:0] jump_target_one_ff;
  logic [9:0] jump_target_two_ff;
  logic [16:0] br_ctl_ff;
  logic [9:0] br_dest_ff;
  mcalu_pkg::mcalu_state_t state_ff;
  mcalu_pkg::mcalu_state_t nxt_state;
  mcalu_pkg::mcalu_op_t op_ff;
  logic [2:0] dst_ff;
  logic [4:0] cnt_ff;
  logic [31:0] mcand_ff;
  logic [15:0] mplr_ff;
  logic [31:0] prod_ff;
  logic done_ff;

  // Write and read channel holding registers
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  logic wr_fire;
  logic busy;
  logic wr_hit;
  logic wr_any;
  logic is_gpr_w;
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign busy = (state_ff != mcalu_pkg::ST_IDLE);
  assign wr_any = |wstrb_ff;
  assign is_gpr_w = (waddr_ff <= mcalu_pkg::ADDR_GPR_LAST);

  // Address and data accepted independently, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_got_ff) begin
        aw_got_ff <= 1'b1;
        waddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got_ff) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  // Ready only while the slot is empty, so a held valid is taken once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_got_ff & ~(s_axi_awvalid & s_axi_awready) & ~wr_fire;
      s_axi_wready <= ~w_got_ff & ~(s_axi_wvalid & s_axi_wready) & ~wr_fire;
    end
  end

  // Write decode: unmapped offsets answer SLVERR
  always_comb begin
    wr_hit = 1'b1;
    unique case (waddr_ff)
      mcalu_pkg::ADDR_COND, mcalu_pkg::ADDR_IMM_LO, mcalu_pkg::ADDR_IMM_HI, mcalu_pkg::ADDR_CMD,
      mcalu_pkg::ADDR_JT_ONE, mcalu_pkg::ADDR_JT_TWO, mcalu_pkg::ADDR_BR_CTL: wr_hit = 1'b1;
      default: wr_hit = is_gpr_w;
    endcase
  end

  // Write response; dropped writes to writable offsets still answer OKAY
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= mcalu_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? mcalu_pkg::RESP_OKAY : mcalu_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Command decode from the held write data
  logic cmd_fire;
  mcalu_pkg::mcalu_op_t cmd_op;
  logic cmd_legal;
  logic [2:0] cmd_dst;
  logic [2:0] cmd_src;
  logic [15:0] opa;
  logic [15:0] opb;
  logic [3:0] cmd_cnt;
  always_comb begin
    cmd_op = mcalu_pkg::mcalu_op_t'(wdata_ff[mcalu_pkg::CMD_OP_LSB +: 5]);
    cmd_legal = (wdata_ff[mcalu_pkg::CMD_OP_LSB +: 5] <= 5'(mcalu_pkg::OP_STAL));
    cmd_dst = wdata_ff[mcalu_pkg::CMD_DST_LSB +: 3];
    cmd_src = wdata_ff[mcalu_pkg::CMD_SRC_LSB +: 3];
    cmd_cnt = wdata_ff[mcalu_pkg::CMD_CNT_LSB +: 4];
    opa = general_regs[cmd_dst];
    opb = wdata_ff[mcalu_pkg::CMD_IMM_BIT] ? imm_ff : general_regs[cmd_src];
  end
  // Busy ignores every command but the configuration one
  assign cmd_fire = wr_fire & wr_any & (waddr_ff == mcalu_pkg::ADDR_CMD) & cmd_legal
                    & (~busy | (cmd_op == mcalu_pkg::OP_STAL));

  // Single-cycle arithmetic and logic results
  logic [16:0] sum17;
  logic is_sub;
  logic s_ovf;
  logic u_ovr;
  logic u_und;
  logic s_ovr;
  logic s_und;
  logic [15:0] as_res;
  logic [15:0] lg_res;
  logic [1:0] lim;
  always_comb begin
    is_sub = (cmd_op == mcalu_pkg::OP_SUB);
    sum17 = is_sub ? ({1'b0, opa} - {1'b0, opb}) : ({1'b0, opa} + {1'b0, opb});
    s_ovf = is_sub ? ((opa[15] != opb[15]) && (sum17[15] != opa[15]))
                   : ((opa[15] == opb[15]) && (sum17[15] != opa[15]));
    u_ovr = ~is_sub & sum17[16];
    u_und = is_sub & sum17[16];
    s_ovr = s_ovf & ~opa[15];
    s_und = s_ovf & opa[15];
    lim = cond_ff[mcalu_pkg::FLG_LIM_HI:mcalu_pkg::FLG_LIM_LO];
    as_res = sum17[15:0];
    if (lim == mcalu_pkg::LIM_SIGNED) begin
      if (s_ovr) as_res = mcalu_pkg::SAT_S_MAX;
      if (s_und) as_res = mcalu_pkg::SAT_S_MIN;
    end else if (lim == mcalu_pkg::LIM_UNSIGNED) begin
      if (u_ovr) as_res = mcalu_pkg::SAT_U_MAX;
      if (u_und) as_res = mcalu_pkg::SAT_U_MIN;
    end
    // NOT here means operand and inverted mask
    unique case (cmd_op)
      mcalu_pkg::OP_AND: lg_res = opa & opb;
      mcalu_pkg::OP_NOT: lg_res = opa & ~opb;
      mcalu_pkg::OP_OR: lg_res = opa | opb;
      mcalu_pkg::OP_XOR: lg_res = opa ^ opb;
      mcalu_pkg::OP_INV: lg_res = ~opa;
      mcalu_pkg::OP_TO_SIGNED: lg_res = cond_ff[mcalu_pkg::FLG_SIGN_PROD] ? 16'(-opa) : opa;
      mcalu_pkg::OP_TOINT: lg_res = opa[15] ? 16'(-opa) : opa;
      mcalu_pkg::OP_BYTE_LEFT: lg_res = {opa[7:0], 8'h00};
      mcalu_pkg::OP_BYTE_RIGHT: lg_res = {8'h00, opa[15:8]};
      mcalu_pkg::OP_SWAP: lg_res = {opa[7:0], opa[15:8]};
      default: lg_res = opa;
    endcase
  end

  // Multi-cycle step values
  logic [15:0] sh_val;
  logic sh_out;
  logic [31:0] sh32_val;
  logic sh32_out;
  logic [31:0] prod_nxt;
  always_comb begin
    unique case (op_ff)
      mcalu_pkg::OP_SHL, mcalu_pkg::OP_SHLS: begin
        sh_val = {general_regs[dst_ff][14:0], 1'b0};
        sh_out = general_regs[dst_ff][15];
      end
      mcalu_pkg::OP_SHRS: begin
        sh_val = {general_regs[dst_ff][15], general_regs[dst_ff][15:1]};
        sh_out = general_regs[dst_ff][0];
      end
      default: begin
        sh_val = {1'b0, general_regs[dst_ff][15:1]};
        sh_out = general_regs[dst_ff][0];
      end
    endcase
    if (op_ff == mcalu_pkg::OP_WIDE_LEFT) begin
      sh32_val = {general_regs[mcalu_pkg::GPR_PROD_HI][14:0], general_regs[mcalu_pkg::GPR_PROD_LO], 1'b0};
      sh32_out = general_regs[mcalu_pkg::GPR_PROD_HI][15];
    end else begin
      sh32_val = {1'b0, general_regs[mcalu_pkg::GPR_PROD_HI], general_regs[mcalu_pkg::GPR_PROD_LO][15:1]};
      sh32_out = general_regs[mcalu_pkg::GPR_PROD_LO][0];
    end
    prod_nxt = mplr_ff[0] ? prod_ff + mcand_ff : prod_ff;
  end

  // Sequencer for multiply and shifts; done low while it runs
  always_comb begin
    nxt_state = state_ff;
    if (state_ff == mcalu_pkg::ST_IDLE) begin
      if (cmd_fire) begin
        unique case (cmd_op)
          mcalu_pkg::OP_MUL: nxt_state = mcalu_pkg::ST_MUL;
          mcalu_pkg::OP_SHL, mcalu_pkg::OP_SHR, mcalu_pkg::OP_SHLS,
          mcalu_pkg::OP_SHRS: nxt_state = mcalu_pkg::ST_SHIFT;
          mcalu_pkg::OP_WIDE_LEFT, mcalu_pkg::OP_WIDE_RIGHT: nxt_state = mcalu_pkg::ST_SHIFT32;
          default: nxt_state = mcalu_pkg::ST_IDLE;
        endcase
      end
    end else if (cnt_ff == 5'h01) begin
      nxt_state = mcalu_pkg::ST_IDLE;
    end
  end

  // Sequencer state and step counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= mcalu_pkg::ST_IDLE;
      op_ff <= mcalu_pkg::OP_ADD;
      dst_ff <= 3'h0;
      cnt_ff <= 5'h00;
      done_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      done_ff <= (nxt_state == mcalu_pkg::ST_IDLE);
      if (!busy && cmd_fire) begin
        op_ff <= cmd_op;
        dst_ff <= cmd_dst;
        cnt_ff <= (cmd_op == mcalu_pkg::OP_MUL) ? mcalu_pkg::MUL_STEPS : 5'(cmd_cnt) + 5'h01;
      end else if (busy) begin
        cnt_ff <= cnt_ff - 5'h01;
      end
    end
  end
  assign operation_done_flag = done_ff;

  // Shift-add multiplier datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcand_ff <= 32'h0000_0000;
      mplr_ff <= 16'h0000;
      prod_ff <= 32'h0000_0000;
    end else if (!busy && cmd_fire && cmd_op == mcalu_pkg::OP_MUL) begin
      mcand_ff <= {16'h0000, opa};
      mplr_ff <= opb;
      prod_ff <= 32'h0000_0000;
    end else if (state_ff == mcalu_pkg::ST_MUL) begin
      prod_ff <= prod_nxt;
      mcand_ff <= {mcand_ff[30:0], 1'b0};
      mplr_ff <= {1'b0, mplr_ff[15:1]};
    end
  end

  // Register file; software writes only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        general_regs[i] <= 16'h0000;
      end
    end else if (busy) begin
      if (state_ff == mcalu_pkg::ST_SHIFT) begin
        general_regs[dst_ff] <= sh_val;
      end else if (state_ff == mcalu_pkg::ST_SHIFT32) begin
        general_regs[mcalu_pkg::GPR_PROD_HI] <= sh32_val[31:16];
        general_regs[mcalu_pkg::GPR_PROD_LO] <= sh32_val[15:0];
      end else if (cnt_ff == 5'h01) begin
        general_regs[mcalu_pkg::GPR_PROD_HI] <= prod_nxt[31:16];
        general_regs[mcalu_pkg::GPR_PROD_LO] <= prod_nxt[15:0];
      end
    end else if (wr_fire && is_gpr_w) begin
      general_regs[waddr_ff[4:2]] <= merge16(general_regs[waddr_ff[4:2]], wdata_ff, wstrb_ff);
    end else if (cmd_fire) begin
      if (cmd_op == mcalu_pkg::OP_ADD || cmd_op == mcalu_pkg::OP_SUB) begin
        general_regs[cmd_dst] <= as_res;
      end else if (cmd_op != mcalu_pkg::OP_MUL && cmd_op != mcalu_pkg::OP_STAL) begin
        general_regs[cmd_dst] <= lg_res;
      end
    end
  end

  // Immediate register, low and high halves loaded separately
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imm_ff <= 16'h0000;
    end else if (wr_fire && wstrb_ff[0] && !busy) begin
      if (waddr_ff == mcalu_pkg::ADDR_IMM_LO) imm_ff[7:0] <= wdata_ff[7:0];
      if (waddr_ff == mcalu_pkg::ADDR_IMM_HI) imm_ff[15:8] <= wdata_ff[7:0];
    end
  end

  // Condition flags; each class touches only its own bits
  logic is_mask;
  assign is_mask = (cmd_op inside {mcalu_pkg::OP_AND, mcalu_pkg::OP_NOT, mcalu_pkg::OP_OR,
                                   mcalu_pkg::OP_XOR, mcalu_pkg::OP_INV});
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_ff <= 16'h0000;
    end else if (busy) begin
      if (cmd_fire) begin
        cond_ff[mcalu_pkg::FLG_LIM_HI:mcalu_pkg::FLG_LIM_LO] <= wdata_ff[mcalu_pkg::CMD_MODE_LSB +: 2];
      end
      if (state_ff == mcalu_pkg::ST_SHIFT) begin
        cond_ff[mcalu_pkg::FLG_SHIFT_OUT] <= sh_out;
      end else if (state_ff == mcalu_pkg::ST_SHIFT32) begin
        cond_ff[mcalu_pkg::FLG_SHIFT_OUT] <= sh32_out;
        cond_ff[mcalu_pkg::FLG_PROD_HI] <= nz16(sh32_val[31:16]);
        cond_ff[mcalu_pkg::FLG_PROD_LO] <= nz16(sh32_val[15:0]);
      end else if (cnt_ff == 5'h01) begin
        cond_ff[mcalu_pkg::FLG_PROD_HI] <= nz16(prod_nxt[31:16]);
        cond_ff[mcalu_pkg::FLG_PROD_LO] <= nz16(prod_nxt[15:0]);
      end
    end else if (wr_fire && waddr_ff == mcalu_pkg::ADDR_COND) begin
      cond_ff <= merge16(cond_ff, wdata_ff, wstrb_ff);
    end else if (cmd_fire) begin
      unique case (cmd_op)
        mcalu_pkg::OP_ADD, mcalu_pkg::OP_SUB: begin
          cond_ff[mcalu_pkg::FLG_CARRY] <= sum17[16];
          cond_ff[mcalu_pkg::FLG_ZERO] <= ~nz16(as_res);
          cond_ff[mcalu_pkg::FLG_NEG] <= as_res[15];
          cond_ff[mcalu_pkg::FLG_U_UND] <= u_und;
          cond_ff[mcalu_pkg::FLG_U_OVR] <= u_ovr;
          cond_ff[mcalu_pkg::FLG_S_UND] <= s_und;
          cond_ff[mcalu_pkg::FLG_S_OVR] <= s_ovr;
        end
        mcalu_pkg::OP_TOINT: begin
          // Reset option restarts the running sign product
          cond_ff[mcalu_pkg::FLG_SIGN_PROD] <= opa[15] ^
            (cond_ff[mcalu_pkg::FLG_SIGN_PROD] & ~wdata_ff[mcalu_pkg::CMD_RST_BIT]);
        end
        mcalu_pkg::OP_STAL: begin
          cond_ff[mcalu_pkg::FLG_LIM_HI:mcalu_pkg::FLG_LIM_LO] <= wdata_ff[mcalu_pkg::CMD_MODE_LSB +: 2];
        end
        default: begin
          if (is_mask) begin
            cond_ff[mcalu_pkg::FLG_MASK_ONE] <= (lg_res == mcalu_pkg::SAT_U_MAX);
            cond_ff[mcalu_pkg::FLG_MASK_ZERO] <= ~nz16(lg_res);
          end
        end
      endcase
    end
  end

  // Jump targets and branch destination former
  logic [9:0] br_dest;
  always_comb begin
    unique case (br_ctl_ff[mcalu_pkg::BR_SEL_LSB +: 2])
      mcalu_pkg::BR_SEL_ONE: br_dest = jump_target_one_ff;
      mcalu_pkg::BR_SEL_TWO: br_dest = jump_target_two_ff;
      default: br_dest = br_ctl_ff[mcalu_pkg::BR_PC_LSB +: 10] +
        {{5{br_ctl_ff[mcalu_pkg::BR_OFF_LSB + 4]}}, br_ctl_ff[mcalu_pkg::BR_OFF_LSB +: 5]};
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jump_target_one_ff <= 10'h000;
      jump_target_two_ff <= 10'h000;
      br_ctl_ff <= 17'h00000;
      br_dest_ff <= 10'h000;
    end else begin
      br_dest_ff <= br_dest;
      if (wr_fire && wr_any) begin
        if (waddr_ff == mcalu_pkg::ADDR_JT_ONE) jump_target_one_ff <= wdata_ff[9:0];
        if (waddr_ff == mcalu_pkg::ADDR_JT_TWO) jump_target_two_ff <= wdata_ff[9:0];
        if (waddr_ff == mcalu_pkg::ADDR_BR_CTL) br_ctl_ff <= wdata_ff[16:0];
      end
    end
  end

  // Read decode; readable registers succeed even while busy, write-only and unmapped offsets answer SLVERR
  logic [31:0] rd_word;
  logic rd_hit;
  logic [7:0] raddr;
  always_comb begin
    raddr = {s_axi_araddr[7:2], 2'b00};
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (raddr)
      mcalu_pkg::ADDR_COND: rd_word = {16'h0000, cond_ff[15:1], done_ff};
      mcalu_pkg::ADDR_IMM: rd_word = {16'h0000, imm_ff};
      mcalu_pkg::ADDR_JT_ONE: rd_word = {22'h000000, jump_target_one_ff};
      mcalu_pkg::ADDR_JT_TWO: rd_word = {22'h000000, jump_target_two_ff};
      mcalu_pkg::ADDR_BR_CTL: rd_word = {15'h0000, br_ctl_ff};
      mcalu_pkg::ADDR_BR_DEST: rd_word = {22'h000000, br_dest_ff};
      default: begin
        rd_hit = (raddr <= mcalu_pkg::ADDR_GPR_LAST);
        rd_word = rd_hit ? {16'h0000, general_regs[raddr[4:2]]} : 32'h0000_0000;
      end
    endcase
  end

  // Read channel: one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= mcalu_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? mcalu_pkg::RESP_OKAY : mcalu_pkg::RESP_SLVERR;
    end else if (rvalid_ff) begin
      if (s_axi_rready) rvalid_ff <= 1'b0;
    end else begin
      arready_ff <= 1'b1;
    end
  end
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

endmodule

//--- dv/mcalu_assertions.sv
// Port-level checks for the ALU datapath top
`timescale 1ns/1ps
module mcalu_assertions (
  // Clock, reset and status
  input wire logic aclk, aresetn, operation_done_flag,
  // Bus handshakes and payloads
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_araddr, s_axi_rdata
);
  // One clock domain only
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Longest jobs, the multiply and a count-15 shift, take 16 steps
  a_done_bound: assert property ($fell(operation_done_flag) |-> ##[1:17] operation_done_flag)
    else $error("busy too long");
  a_done_reset: assert property (disable iff (1'b0) !aresetn |=> operation_done_flag)
    else $error("done low after reset");
  a_done_bit: assert property ($stable(operation_done_flag) && s_axi_arvalid && s_axi_arready
    && s_axi_araddr[7:0] == 8'h20 |=> s_axi_rdata[0] == $past(operation_done_flag)) else $error("done bit");
  a_read_ok: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr[7:2] <= 6'h08 || s_axi_araddr[7:2] == 6'h0b) |=> s_axi_rvalid && s_axi_rresp == 2'h0)
    else $error("register read refused");
  a_read_unmap: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h10
    |=> s_axi_rvalid && s_axi_rresp == 2'h2) else $error("unmapped read accepted");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write overlap");
  // Main scenarios reached
  c_busy: cover property ($fell(operation_done_flag));
  c_idle: cover property ($rose(operation_done_flag));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind mcalu_top mcalu_assertions mcalu_assertions_inst (.*);

//--- dv/mcalu_decoder_model.sv
// Decoder-side bus master issuing ALU register and command traffic
`timescale 1ns/1ps
module mcalu_decoder_model (
  // Clock and status
  input wire logic aclk, operation_done_flag,
  // Requests toward the ALU
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
  output logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr,
  output logic [3:0] s_axi_wstrb,
  // Answers from the ALU
  input wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {3{32'h5a5a_a5a5}};
    s_axi_wstrb = 4'hf;
  end
  // Released payloads invert so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~s_axi_awaddr};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    // Ready only once data shows, so the slave must hold it a cycle
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~s_axi_araddr};
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Hold off until the running operation reports done
  task automatic wait_done;
    do @(posedge aclk); while (operation_done_flag !== 1'b1);
  endtask
endmodule

//--- dv/tb_microcore_alu_datapath.sv
// Self-checking bench for the ALU datapath
`timescale 1ns/1ps
module tb_microcore_alu_datapath;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, operation_done_flag;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_total, tests_run, cyc;
  mcalu_top mcalu_top_inst (.*);
  mcalu_decoder_model mcalu_decoder_model_inst (.*);
  // 100 MHz core clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    mcalu_decoder_model_inst.wr(a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] k, e);
    logic [31:0] d;
    logic [1:0] r;
    mcalu_decoder_model_inst.rd(a, d, r);
    chk($sformatf("addr %h", a), d & k, e);
    chk("read resp", {30'h0, r}, 32'h0);
  endtask
  // Command word: mode/count/imm byte, source, operand, opcode
  task automatic cmd(input logic [4:0] o, input logic [2:0] dst, src, input logic [7:0] hi);
    w(8'h30, {13'h0, hi, src, dst, o});
  endtask
  task automatic t_modes;
    logic [31:0] ae[4] = '{32'h8000, 32'h7fff, 32'h8000, 32'h8000};
    for (int m = 0; m < 4; m++) begin
      cmd(5'h13, 3'h0, 3'h0, {m[1:0], 6'h00});
      w(8'h00, 32'h7fff);
      w(8'h04, 32'h0001);
      cmd(5'h00, 3'h0, 3'h1, 8'h00);
      rc(8'h00, 32'hffff, ae[m]);
      w(8'h00, 32'h0000);
      cmd(5'h01, 3'h0, 3'h1, 8'h00);
      rc(8'h00, 32'hffff, (m == 3) ? 32'h0000 : 32'hffff);
      rc(8'h20, 32'h1811, {19'h0, m[1:0], 11'h011});
    end
  endtask
  // Multiply with requests thrown at it while busy
  task automatic t_mul;
    w(8'h08, 32'h0100);
    w(8'h0c, 32'h0300);
    cmd(5'h02, 3'h2, 3'h3, 8'h00);
    w(8'h00, 32'h5555);
    chk("done", {31'h0, operation_done_flag}, 32'h0);
    cmd(5'h00, 3'h2, 3'h3, 8'h00);
    rc(8'h08, 32'hffff, 32'h0100);
    mcalu_decoder_model_inst.wait_done();
    rc(8'h18, 32'hffff, 32'h0003);
    rc(8'h1c, 32'hffff, 32'h0000);
    rc(8'h00, 32'hffff, 32'h0000);
    rc(8'h20, 32'h0180, 32'h0100);
  endtask
  task automatic t_shift_logic;
    w(8'h10, 32'h9001);
    cmd(5'h0a, 3'h4, 3'h0, 8'h06);
    mcalu_decoder_model_inst.wait_done();
    rc(8'h10, 32'hffff, 32'h0010);
    rc(8'h20, 32'h8000, 32'h8000);
    w(8'h24, 32'h000f);
    w(8'h28, 32'h00f0);
    rc(8'h2c, 32'hffff, 32'hf00f);
    w(8'h14, 32'h0ff0);
    cmd(5'h05, 3'h5, 3'h0, 8'h01);
    rc(8'h14, 32'hffff, 32'hffff);
    rc(8'h20, 32'h0600, 32'h0200);
    cmd(5'h06, 3'h5, 3'h5, 8'h00);
    rc(8'h20, 32'h0600, 32'h0400);
  endtask
  task automatic t_conv_branch;
    logic [31:0] ctl[4] = '{32'h8000, 32'h10000, 32'h4005, 32'h3ffa};
    logic [31:0] de[4] = '{32'h155, 32'h2aa, 32'h3f5, 32'h009};
    logic [31:0] d;
    logic [1:0] r;
    w(8'h00, 32'hfffe);
    cmd(5'h09, 3'h0, 3'h0, 8'h20);
    rc(8'h00, 32'hffff, 32'h0002);
    rc(8'h20, 32'h4000, 32'h4000);
    cmd(5'h08, 3'h0, 3'h0, 8'h00);
    rc(8'h00, 32'hffff, 32'hfffe);
    w(8'h34, 32'h155);
    w(8'h38, 32'h2aa);
    for (int i = 0; i < 4; i++) begin
      w(8'h3c, ctl[i]);
      rc(8'h40, 32'h3ff, de[i]);
    end
    mcalu_decoder_model_inst.rd(8'h44, d, r);
    chk("unmapped", {30'h0, r}, 32'h2);
    mcalu_decoder_model_inst.wr(8'h44, 32'h0, r);
    chk("wr unmapped", {30'h0, r}, 32'h2);
  endtask
  // Byte moves, swap and a wide right shift on the product pair
  task automatic t_byte_wide;
    w(8'h00, 32'h12f4);
    cmd(5'h12, 3'h0, 3'h0, 8'h00);
    rc(8'h00, 32'hffff, 32'hf412);
    cmd(5'h10, 3'h0, 3'h0, 8'h00);
    rc(8'h00, 32'hffff, 32'h1200);
    cmd(5'h11, 3'h0, 3'h0, 8'h00);
    rc(8'h00, 32'hffff, 32'h0012);
    w(8'h18, 32'h0001);
    w(8'h1c, 32'h8000);
    cmd(5'h0f, 3'h0, 3'h0, 8'h02);
    mcalu_decoder_model_inst.wait_done();
    rc(8'h18, 32'hffff, 32'h0000);
    rc(8'h1c, 32'hffff, 32'h6000);
    rc(8'h20, 32'h8180, 32'h0080);
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // Reset, then the scenarios in turn
  initial begin
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_modes();
    t_mul();
    t_shift_logic();
    t_byte_wide();
    t_conv_branch();
    complete_run();
  end
endmodule
